// ---- iss_slave.sv ----
`timescale 1ns/10ps
`include "iss_regs.svh"
module iss_slave (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [1:0] portModeSelect,
    input wire logic startIrqEnable,
    input wire logic stopIrqEnable,
    input wire logic addressHoldEnable,
    input wire logic dataHoldEnable,
    input wire logic bufferOverrideEnable,
    input wire logic stretchEnable,
    input wire logic slaveCollisionDetectEnable,
    input wire logic ackValueToSend,
    input wire logic [7:0] slaveAddressWrData,
    input wire logic slaveAddressWrite,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic clockReleaseSet,
    input wire logic irqFlagClear,
    input wire logic overflowClear,
    input wire logic collisionClear,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic [7:0] slaveAddress,
    output logic portIrqFlag,
    output logic busCollisionFlag,
    output logic receiveOverflowFlag,
    output logic bufferFullFlag,
    output logic updateAddressFlag,
    output logic ackTimeFlag,
    output logic ackReceivedStatus,
    output logic clockReleaseBit,
    output logic readWriteStatus,
    output logic startSeen,
    output logic stopSeen
);
    ///////////////////////////////////////////////////////////////////////
    // pin synchronisers and conditions
    logic [1:0] sclSync_reg;
    logic [1:0] sdaSync_reg;
    logic sclQ_reg;
    logic sdaQ_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            sclQ_reg <= 1'b1;
            sdaQ_reg <= 1'b1;
        end else begin
            sclSync_reg <= {sclSync_reg[0], sclIn};
            sdaSync_reg <= {sdaSync_reg[0], sdaIn};
            sclQ_reg <= sclSync_reg[1];
            sdaQ_reg <= sdaSync_reg[1];
        end
    end
    logic scl;
    logic sda;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic sclLowSeen_reg;
    assign scl = sclSync_reg[1];
    assign sda = sdaSync_reg[1];
    assign sclRise = scl && !sclQ_reg;
    assign sclFall = !scl && sclQ_reg;
    assign startCond = scl && sclQ_reg && sdaQ_reg && !sda;
    assign stopCond = scl && sclQ_reg && !sdaQ_reg && sda && sclLowSeen_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclLowSeen_reg <= 1'b0;
        end else if (startCond) begin
            sclLowSeen_reg <= 1'b0;
        end else if (!scl) begin
            sclLowSeen_reg <= 1'b1;
        end
    end
    ///////////////////////////////////////////////////////////////////////
    // byte engine
    iss_pkg::iss_state_e state_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] shift_reg;
    logic tenBit;
    logic irqMode;
    logic addrPhase_reg;
    logic tenLow_reg;
    logic tenMatched_reg;
    logic ackDrive_reg;
    logic sendAck_reg;
    logic holdAtEight_reg;
    logic [7:0] rxByte;
    logic addrMatch;
    logic full;
    logic fifoInReady;
    logic busCollide;
    assign tenBit = portModeSelect[0];
    assign irqMode = portModeSelect[1];
    assign rxByte = {shift_reg[6:0], sda};
    assign full = bufferFullFlag || receiveOverflowFlag;
    function automatic logic match7(input logic [7:0] b, input logic [7:0] a);
        match7 = (b[7:1] == a[7:1]);
    endfunction
    function automatic logic matchHigh(input logic [7:0] b, input logic [7:0] a);
        matchHigh = (b[7:3] == `ISS_TEN_HIGH_TAG) && (b[2:1] == a[2:1]);
    endfunction
    always_comb begin
        if (!tenBit) begin
            addrMatch = match7(shift_reg, slaveAddress);
        end else if (tenLow_reg) begin
            addrMatch = (shift_reg == slaveAddress);
        end else begin
            addrMatch = matchHigh(shift_reg, slaveAddress);
        end
    end
    logic ninthRise;
    logic ninthFall;
    assign ninthRise = sclRise && (bitCnt_reg == `ISS_ACK_PULSE);
    assign ninthFall = sclFall && (bitCnt_reg == `ISS_ACK_PULSE);
    logic irqSet;
    logic holdSet;
    logic ackFall;
    assign ackFall = sclFall && (bitCnt_reg == `ISS_BITS_PER_BYTE);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= iss_pkg::ST_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= `ISS_BYTE_ZERO;
            addrPhase_reg <= 1'b0;
            tenLow_reg <= 1'b0;
            tenMatched_reg <= 1'b0;
            ackDrive_reg <= 1'b0;
            sendAck_reg <= 1'b0;
            holdAtEight_reg <= 1'b0;
            readWriteStatus <= 1'b0;
            ackReceivedStatus <= 1'b0;
            rxData <= `ISS_BYTE_ZERO;
        end else if (startCond) begin
            state_reg <= iss_pkg::ST_ADDR;
            bitCnt_reg <= 4'h0;
            addrPhase_reg <= 1'b1;
            tenLow_reg <= 1'b0;
            ackDrive_reg <= 1'b0;
        end else if (stopCond) begin
            state_reg <= iss_pkg::ST_IDLE;
            tenMatched_reg <= 1'b0;
            ackDrive_reg <= 1'b0;
        end else if (busCollide) begin
            state_reg <= iss_pkg::ST_IDLE;
            ackDrive_reg <= 1'b0;
        end else if (state_reg != iss_pkg::ST_IDLE) begin
            if (sclRise && bitCnt_reg < `ISS_BITS_PER_BYTE) begin
                shift_reg <= rxByte;
                bitCnt_reg <= bitCnt_reg + 4'h1;
            end
            if (ninthRise && state_reg == iss_pkg::ST_SEND) begin
                ackReceivedStatus <= sda;
            end
            if (clockReleaseSet) begin
                holdAtEight_reg <= 1'b0;
            end
            if (ackFall) begin
                bitCnt_reg <= `ISS_ACK_PULSE;
                if (state_reg == iss_pkg::ST_SEND) begin
                    ackDrive_reg <= 1'b0;
                end else if (state_reg == iss_pkg::ST_ADDR) begin
                    if (addrMatch && (!tenBit || tenLow_reg || !shift_reg[0]
                            || tenMatched_reg)) begin
                        if (!(tenBit && tenLow_reg)) begin
                            readWriteStatus <= shift_reg[0];
                        end
                        rxData <= shift_reg;
                        sendAck_reg <= !full || bufferOverrideEnable;
                        holdAtEight_reg <= addressHoldEnable;
                        ackDrive_reg <= 1'b1;
                        if (tenBit && tenLow_reg) begin
                            tenMatched_reg <= 1'b1;
                        end
                    end else if (tenBit && tenLow_reg) begin
                        ackDrive_reg <= 1'b0;
                        tenMatched_reg <= 1'b0;
                    end else begin
                        state_reg <= iss_pkg::ST_IDLE;
                    end
                end else begin
                    rxData <= shift_reg;
                    sendAck_reg <= !full || bufferOverrideEnable;
                    holdAtEight_reg <= dataHoldEnable;
                    ackDrive_reg <= 1'b1;
                end
            end
            if (ninthFall) begin
                bitCnt_reg <= 4'h0;
                ackDrive_reg <= 1'b0;
                if (state_reg == iss_pkg::ST_SEND && ackReceivedStatus) begin
                    state_reg <= iss_pkg::ST_IDLE;
                end else if (state_reg == iss_pkg::ST_ADDR) begin
                    if (tenBit && !tenLow_reg && !readWriteStatus) begin
                        tenLow_reg <= 1'b1;
                    end else if (tenBit && tenLow_reg && !tenMatched_reg) begin
                        state_reg <= iss_pkg::ST_IDLE;
                        tenLow_reg <= 1'b0;
                    end else begin
                        state_reg <= readWriteStatus ? iss_pkg::ST_SEND : iss_pkg::ST_RECV;
                        tenLow_reg <= 1'b0;
                    end
                end
            end
            if (state_reg == iss_pkg::ST_SEND && txValid) begin
                shift_reg <= txData;
            end
        end
    end
    ///////////////////////////////////////////////////////////////////////
    // pin drive
    logic sdaDrive;
    logic sendBit_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sendBit_reg <= 1'b1;
        end else if (state_reg == iss_pkg::ST_SEND && bitCnt_reg < `ISS_BITS_PER_BYTE
                && (sclFall || txValid)) begin
            sendBit_reg <= txValid ? txData[7] : shift_reg[7];
        end
    end
    assign busCollide = slaveCollisionDetectEnable && state_reg == iss_pkg::ST_SEND
        && bitCnt_reg < `ISS_BITS_PER_BYTE && sclRise && sendBit_reg && !sda;
    assign sdaDrive = (ackDrive_reg && sendAck_reg && !ackValueToSend && !holdAtEight_reg)
        || (state_reg == iss_pkg::ST_SEND && bitCnt_reg < `ISS_ACK_PULSE
            && !sendBit_reg);
    assign sdaOut = 1'b0;
    assign sdaOe = sdaDrive;
    logic sclHold_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclHold_reg <= 1'b0;
        end else if ((!clockReleaseBit || updateAddressFlag) && !scl) begin
            sclHold_reg <= 1'b1;
        end else if (clockReleaseBit && !updateAddressFlag) begin
            sclHold_reg <= 1'b0;
        end
    end
    assign sclOut = 1'b0;
    assign sclOe = sclHold_reg;
    ///////////////////////////////////////////////////////////////////////
    // status flags
    logic matchedByte;
    assign matchedByte = ackFall && (state_reg == iss_pkg::ST_RECV
        || (state_reg == iss_pkg::ST_ADDR && addrMatch));
    assign holdSet = matchedByte && ((state_reg == iss_pkg::ST_ADDR && addressHoldEnable)
        || (state_reg == iss_pkg::ST_RECV && dataHoldEnable));
    logic ackedNinth;
    assign ackedNinth = ninthFall && state_reg != iss_pkg::ST_IDLE
        && (state_reg == iss_pkg::ST_SEND || (sendAck_reg && !ackValueToSend));
    assign irqSet = holdSet || ackedNinth || (ackFall && tenBit && tenLow_reg)
        || ((startCond || stopCond) && (irqMode || (startCond ? startIrqEnable
            : stopIrqEnable)));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            portIrqFlag <= 1'b0;
        end else if (irqSet) begin
            portIrqFlag <= 1'b1;
        end else if (irqFlagClear) begin
            portIrqFlag <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clockReleaseBit <= 1'b1;
        end else if (holdSet
                || (ninthFall && state_reg == iss_pkg::ST_ADDR && readWriteStatus
                    && !(tenBit && !tenLow_reg && !readWriteStatus))
                || (ninthFall && state_reg == iss_pkg::ST_SEND && !ackReceivedStatus)
                || (ninthFall && stretchEnable && state_reg != iss_pkg::ST_SEND
                    && state_reg != iss_pkg::ST_IDLE)) begin
            clockReleaseBit <= 1'b0;
        end else if (clockReleaseSet) begin
            clockReleaseBit <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ackTimeFlag <= 1'b0;
        end else if (ackFall && (addressHoldEnable || dataHoldEnable)
                && (matchedByte || state_reg == iss_pkg::ST_SEND)) begin
            ackTimeFlag <= 1'b1;
        end else if (ninthFall || startCond) begin
            ackTimeFlag <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            updateAddressFlag <= 1'b0;
            slaveAddress <= `ISS_BYTE_ZERO;
        end else begin
            if (ninthFall && tenBit && state_reg == iss_pkg::ST_ADDR
                    && (tenLow_reg || !readWriteStatus)) begin
                updateAddressFlag <= 1'b1;
            end else if (slaveAddressWrite) begin
                updateAddressFlag <= 1'b0;
            end
            if (slaveAddressWrite) begin
                slaveAddress <= slaveAddressWrData;
            end
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            startSeen <= 1'b0;
            stopSeen <= 1'b0;
        end else if (startCond) begin
            startSeen <= 1'b1;
            stopSeen <= 1'b0;
        end else if (stopCond) begin
            startSeen <= 1'b0;
            stopSeen <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busCollisionFlag <= 1'b0;
            receiveOverflowFlag <= 1'b0;
        end else begin
            if (busCollide) begin
                busCollisionFlag <= 1'b1;
            end else if (collisionClear) begin
                busCollisionFlag <= 1'b0;
            end
            if (matchedByte && full) begin
                receiveOverflowFlag <= 1'b1;
            end else if (overflowClear) begin
                receiveOverflowFlag <= 1'b0;
            end
        end
    end
    ///////////////////////////////////////////////////////////////////////
    // received byte buffer
    logic pushByte;
    assign pushByte = matchedByte && (!full || bufferOverrideEnable) && fifoInReady;
    assign bufferFullFlag = rxValid;
    logic [7:0] rxData_unused;
    iss_fifo #(.WIDTH(8), .DEPTH(`ISS_FIFO_DEPTH)) rxFifo (
        .clk(clk),
        .arst_n(arst_n),
        .inValid(pushByte),
        .inReady(fifoInReady),
        .inData(shift_reg),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxData_unused)
    );
endmodule

// ---- iss_regs.svh ----
`ifndef ISS_REGS_SVH
`define ISS_REGS_SVH
`define ISS_BITS_PER_BYTE 4'h8
`define ISS_ACK_PULSE 4'h9
`define ISS_TEN_HIGH_TAG 5'h1E
`define ISS_MODE_7BIT 2'h0
`define ISS_MODE_10BIT 2'h1
`define ISS_MODE_7BIT_IRQ 2'h2
`define ISS_MODE_10BIT_IRQ 2'h3
`define ISS_FIFO_DEPTH 32
`define ISS_BYTE_ZERO 8'h00
`endif

// ---- iss_pkg.sv ----
package iss_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_RECV,
        ST_SEND,
        ST_WAIT
    } iss_state_e;
    typedef logic [7:0] iss_byte_t;
endpackage

// ---- iss_fifo.sv ----
`timescale 1ns/10ps
module iss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_reg;
    logic [AW:0] rdPtr_reg;
    logic full;
    logic empty;
    assign empty = (wrPtr_reg == rdPtr_reg);
    assign full = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_reg[AW-1:0]];
    always_ff @(posedge clk) begin
        if (inValid && !full) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= '0;
        end else if (inValid && !full) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdPtr_reg <= '0;
        end else if (outReady && !empty) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
        end
    end
endmodule

// ---- iss_slave_props.sv ----
`timescale 1ns/10ps
////////////////////////////////////////
module iss_slave_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic slaveAddressWrite,
    input wire logic irqFlagClear,
    input wire logic portIrqFlag,
    input wire logic updateAddressFlag,
    input wire logic ackReceivedStatus,
    input wire logic clockReleaseBit,
    input wire logic startSeen,
    input wire logic stopSeen
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_hold_after_low;
        $rose(sclOe) |-> !$past(sclIn) && !sclIn;
    endproperty
    a_hold_after_low: assert property (p_hold_after_low) else $error("clock held while high");
    property p_release;
        (clockReleaseBit && !updateAddressFlag) [*3] |-> !sclOe;
    endproperty
    a_release: assert property (p_release) else $error("clock held after release");
    property p_ua_hold;
        (updateAddressFlag && !sclIn) [*6] |-> sclOe;
    endproperty
    a_ua_hold: assert property (p_ua_hold) else $error("clock not held for address update");
    property p_ua_clear;
        $fell(updateAddressFlag) |-> $past(slaveAddressWrite);
    endproperty
    a_ua_clear: assert property (p_ua_clear) else $error("update flag fell without write");
    property p_irq_sticky;
        portIrqFlag && !irqFlagClear |=> portIrqFlag;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag dropped by itself");
    property p_irq_clear;
        $fell(portIrqFlag) |-> $past(irqFlagClear);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq flag fell without clear");
    property p_ack_stat;
        $changed(ackReceivedStatus) |-> $past(sclIn) && !$past(sdaOe);
    endproperty
    a_ack_stat: assert property (p_ack_stat) else $error("ack status moved off clock high");
    property p_sda_drive;
        $rose(sdaOe) |-> !$past(sclIn) && !sclIn;
    endproperty
    a_sda_drive: assert property (p_sda_drive) else $error("data driven while clock high");
    property p_start;
        $rose(startSeen) |-> $past(sclIn, 2) && !$past(sdaIn);
    endproperty
    a_start: assert property (p_start) else $error("start flag without start");
    property p_stop;
        $rose(stopSeen) |-> $past(sclIn) && $past(sdaIn);
    endproperty
    a_stop: assert property (p_stop) else $error("stop flag without stop");
endmodule
bind iss_slave iss_slave_props i_iss_slave_props (.clk, .arst_n, .sclIn, .sdaIn, .sclOe,
    .sdaOe, .slaveAddressWrite, .irqFlagClear, .portIrqFlag, .updateAddressFlag,
    .ackReceivedStatus, .clockReleaseBit, .startSeen, .stopSeen);

// ---- iss_bus_master.sv ----
`timescale 1ns/10ps
////////////////////////////////////////
module iss_bus_master (
    output logic sclLow,
    output logic sdaLow,
    input wire logic scl,
    input wire logic sda
);
    localparam realtime Q = 31.25;
    initial {sclLow, sdaLow} = 2'h0;
    // release the clock and wait out a stretch of up to 4000 polls of 5 ns
    task automatic rise();
        int n;
        n = 0;
        sclLow = 1'b0;
        while (!scl && n < 4000) begin
            #5;
            n++;
        end
    endtask
    task automatic slot(input logic b, output logic v);
        sdaLow = !b;
        #Q;
        rise();
        #Q;
        v = sda;
        #Q;
        sclLow = 1'b1;
        #Q;
    endtask
    task automatic start();
        if (sclLow) begin
            sdaLow = 1'b0;
            #Q;
            rise();
            #Q;
        end
        sdaLow = 1'b1;
        #(2 * Q);
        sclLow = 1'b1;
        #Q;
    endtask
    task automatic stop();
        sdaLow = 1'b1;
        #Q;
        rise();
        #Q;
        sdaLow = 1'b0;
        #(2 * Q);
    endtask
    task automatic wr(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) slot(v[i], ack);
        slot(1'b1, ack);
    endtask
    task automatic rd(input logic [7:0] drv, input logic nak, output logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) slot(drv[i], v[i]);
        slot(nak, a);
    endtask
endmodule

// ---- iss_slave_tb.sv ----
`timescale 1ns/10ps
`include "iss_regs.svh"
module iss_slave_tb;
    logic clk, arst_n, sclW, sdaW, mScl, mSda, ack, uaW;
    logic sclOut, sclOe, sdaOut, sdaOe, rxValid, rxReady, txValid, clockReleaseSet;
    logic startIrqEnable, stopIrqEnable, addressHoldEnable, dataHoldEnable;
    logic bufferOverrideEnable, stretchEnable, slaveCollisionDetectEnable, ackValueToSend;
    logic slaveAddressWrite, irqFlagClear, overflowClear, collisionClear;
    logic portIrqFlag, busCollisionFlag, receiveOverflowFlag, bufferFullFlag;
    logic updateAddressFlag, ackTimeFlag, ackReceivedStatus, clockReleaseBit;
    logic readWriteStatus, startSeen, stopSeen;
    logic [1:0] portModeSelect;
    logic [7:0] slaveAddressWrData, txData, rxData, slaveAddress, d, hiA, loA;
    logic [23:0] r;
    // mode, start irq enable, address byte, expected nack, expected start interrupt
    logic [23:0] rows [5] = '{24'h00A400, 24'h01A611, 24'h20A401, 24'h002410, 24'h21A401};
    logic [7:0] rxQ [$];
    int n_errors, total_checks, sw, nHold, nAckTim, h0, t0;
    assign sclW = !(sclOe || mScl);
    assign sdaW = !(sdaOe || mSda);
    iss_slave i_iss_slave (.clk, .arst_n, .sclIn(sclW), .sclOut, .sclOe, .sdaIn(sdaW), .sdaOut,
        .sdaOe, .portModeSelect, .startIrqEnable, .stopIrqEnable, .addressHoldEnable,
        .dataHoldEnable, .bufferOverrideEnable, .stretchEnable, .slaveCollisionDetectEnable,
        .ackValueToSend, .slaveAddressWrData, .slaveAddressWrite, .txData, .txValid,
        .clockReleaseSet, .irqFlagClear, .overflowClear, .collisionClear, .rxData, .rxValid,
        .rxReady, .slaveAddress, .portIrqFlag, .busCollisionFlag, .receiveOverflowFlag,
        .bufferFullFlag, .updateAddressFlag, .ackTimeFlag, .ackReceivedStatus,
        .clockReleaseBit, .readWriteStatus, .startSeen, .stopSeen);
    iss_bus_master i_iss_bus_master (.sclLow(mScl), .sdaLow(mSda), .scl(sclW), .sda(sdaW));
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (rxValid && rxReady) rxQ.push_back(rxData);
    always @(negedge clockReleaseBit) nHold++;
    always @(posedge ackTimeFlag) nAckTim++;
    // local software: loads data, releases the clock, answers address updates
    always @(posedge clk) begin
        #1;
        sw = (updateAddressFlag || !clockReleaseBit) ? sw + 1 : 0;
        txValid = (sw == 8) && readWriteStatus;
        clockReleaseSet = (sw == 16);
        if (sw == 16 && updateAddressFlag) begin
            slaveAddressWrData = (slaveAddress === hiA) ? loA : hiA;
            slaveAddressWrite = 1'b1;
        end else if (uaW) begin
            slaveAddressWrite = 1'b0;
        end
        uaW = (sw == 16 && updateAddressFlag);
    end
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wa(input logic [7:0] a);
        hiA = a;
        slaveAddressWrData = a;
        slaveAddressWrite = 1'b1;
        tick(1);
        slaveAddressWrite = 1'b0;
    endtask
    task automatic clr();
        tick(1);
        {irqFlagClear, overflowClear, collisionClear} = 3'h7;
        tick(1);
        {irqFlagClear, overflowClear, collisionClear} = 3'h0;
    endtask
    task automatic wb(input logic [7:0] v, input logic [7:0] e, input string m);
        i_iss_bus_master.wr(v, ack);
        chk(ack, e, m);
    endtask
    task automatic go();
        i_iss_bus_master.start();
    endtask
    task automatic st();
        i_iss_bus_master.stop();
        tick(4);
    endtask
    ////////////////////////////////////////
    initial begin
        {startIrqEnable, stopIrqEnable, addressHoldEnable, dataHoldEnable} = 4'h0;
        {bufferOverrideEnable, stretchEnable, slaveCollisionDetectEnable, ackValueToSend} = 4'h0;
        {slaveAddressWrite, irqFlagClear, overflowClear, collisionClear, uaW} = 5'h00;
        {txValid, clockReleaseSet, rxReady} = 3'h1;
        {slaveAddressWrData, txData, hiA, loA} = 32'h0096A437;
        portModeSelect = `ISS_MODE_7BIT;
        arst_n = 1'b0;
        tick(2);
        arst_n = 1'b1;
        tick(2);
        chk(clockReleaseBit, 1'b1, "release bit at reset");
        chk(portIrqFlag | sclOe | sdaOe, 1'b0, "idle at reset");
        $display("test reset done");
        wa(8'hA4);
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            portModeSelect = r[21:20];
            startIrqEnable = r[16];
            clr();
            rxQ.delete();
            go();
            tick(4);
            chk(portIrqFlag, r[0], "start interrupt");
            chk(startSeen, 1'b1, "start status");
            wb(r[15:8], r[4], "address ack");
            chk(portIrqFlag, r[0] | !r[4], "address interrupt");
            if (!r[4]) begin
                wb(8'h3C, 8'h00, "data ack");
                tick(4);
                chk(readWriteStatus, 1'b0, "write status");
                chk(rxQ[0], r[15:8], "address in buffer");
                chk(rxQ[1], 8'h3C, "data in buffer");
            end
            st();
            chk(stopSeen, 1'b1, "stop status");
            $display("test row %0d done", i);
        end
        {portModeSelect, startIrqEnable} = 3'h0;
        clr();
        go();
        wb(8'hA5, 8'h00, "read address ack");
        chk(readWriteStatus, 1'b1, "read status");
        i_iss_bus_master.rd(8'hFF, 1'b0, d);
        chk(d, 8'h96, "first sent byte");
        clr();
        i_iss_bus_master.rd(8'hFF, 1'b1, d);
        tick(4);
        chk(d, 8'h96, "last sent byte");
        chk(ackReceivedStatus & portIrqFlag, 1'b1, "nack seen and flag");
        chk(sclOe, 1'b0, "no hold after nack");
        st();
        $display("test read done");
        portModeSelect = `ISS_MODE_10BIT;
        wa(8'hF2);
        go();
        wb(8'hF2, 8'h00, "high byte ack");
        wb(8'h37, 8'h00, "low byte ack");
        chk(readWriteStatus, 1'b0, "ten bit write status");
        wb(8'h3C, 8'h00, "ten bit data ack");
        go();
        wb(8'hF3, 8'h00, "ten bit read ack");
        i_iss_bus_master.rd(8'hFF, 1'b1, d);
        chk(d, 8'h96, "ten bit sent byte");
        st();
        $display("test ten bit done");
        portModeSelect = `ISS_MODE_7BIT;
        wa(8'hA4);
        {addressHoldEnable, dataHoldEnable, h0, t0} = {2'h3, nHold, nAckTim};
        go();
        wb(8'hA4, 8'h00, "held address ack");
        wb(8'h3C, 8'h00, "held data ack");
        chk(nHold - h0 == 2, 1'b1, "holds at eighth fall");
        chk(nAckTim - t0 == 2, 1'b1, "ack time flags");
        tick(1);
        ackValueToSend = 1'b1;
        wb(8'h3C, 8'h01, "software nack");
        st();
        {addressHoldEnable, dataHoldEnable, ackValueToSend, stretchEnable, h0} = {4'h1, nHold};
        go();
        wb(8'hA4, 8'h00, "stretch address ack");
        wb(8'h3C, 8'h00, "stretch data ack");
        chk(nHold > h0, 1'b1, "stretch after byte");
        st();
        {stretchEnable, rxReady} = 2'h0;
        go();
        wb(8'hA4, 8'h00, "unread address ack");
        st();
        chk(bufferFullFlag, 1'b1, "buffer full");
        go();
        wb(8'hA4, 8'h01, "full buffer nack");
        st();
        chk(receiveOverflowFlag, 1'b1, "overflow flag");
        rxReady = 1'b1;
        $display("test hold and full done");
        slaveCollisionDetectEnable = 1'b1;
        clr();
        go();
        wb(8'hA5, 8'h00, "collision address ack");
        i_iss_bus_master.rd(8'h00, 1'b1, d);
        tick(4);
        chk(busCollisionFlag, 1'b1, "collision flag");
        st();
        $display("test collision done");
        results();
    end
    initial begin
        #300000;
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end
endmodule
